// ---- src/pwm_timing_defines.svh ----
// register offsets, field positions and reset values of the pwm timing core
// assumes a 4-bit word address on the register port and 16-bit data
`ifndef PWM_TIMING_DEFINES_SVH
`define PWM_TIMING_DEFINES_SVH

`define ADDR_HALF_PERIOD 4'h0
`define ADDR_DEAD_TIME 4'h1
`define ADDR_MIN_PULSE 4'h2
`define ADDR_SYNC_WIDTH 4'h3
`define ADDR_DUTY_A 4'h4
`define ADDR_DUTY_B 4'h5
`define ADDR_DUTY_C 4'h6
`define ADDR_SEGMENT 4'h7
`define ADDR_MODE 4'h8
`define ADDR_STATUS 4'h9

`define MODE_DOUBLE_BIT 6
`define STATUS_HALF_BIT 3
`define STATUS_RUN_BIT 0

`define SYNC_WIDTH_RESET 8'h27
`define WORD_RESET 16'h0000
`define DEAD_RESET 10'h000
`define PHASES 3

`endif

// ---- src/pwm_timing_pkg.sv ----
// types shared by the pwm timing core and its bench
// assumes the defines header supplies all numeric constants
package pwm_timing_pkg;
  typedef logic [15:0] word_t;
  typedef logic [9:0] dead_t;
  typedef logic [7:0] width_t;
  typedef logic [3:0] addr_t;
  typedef enum logic [0:0] {
    FIRST_HALF = 1'b0,
    SECOND_HALF = 1'b1
  } half_e;
  typedef enum logic [0:0] {
    STOPPED = 1'b0,
    RUNNING = 1'b1
  } run_e;
endpackage

// ---- src/three_phase_pwm_timing_core.sv ----
// three-phase center-based pwm timing core with sync pulse and update modes
// assumes one 10 mhz clock, a synchronous bus master and gate drivers outside
//
// What this block does
// - one clock is the unit; count is half-period
// - full period is twice the half-period count
// - half-period register is 16 bits, up to ffff
// - dead time twice count between complementary edges
// - dead-time register is 10 bits wide
// - zero dead-time count gives no dead time
// - mode bit 6 selects single or double update
// - reset clears mode bit: single update
// - single mode: one sync per period, starts period
// - sync rising edge latches all timing registers
// - segment control latched on sync rising edge
// - double mode adds midpoint sync, latches again
// - status bit 3 shows second half, in double mode only
// - sync pulse lasts width plus one units
// - sync width resets to 0x27
// - sync paces converter, twice rate in double
// - interrupt request on every sync pulse
// - nothing runs until period and duties written
`include "pwm_timing_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module three_phase_pwm_timing_core (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // register port
  input wire pwm_timing_pkg::addr_t addr,
  input wire pwm_timing_pkg::word_t wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output pwm_timing_pkg::word_t rdata,
  // gate drive
  output logic [2:0] phase_high_out,
  output logic [2:0] phase_low_out,
  // sync and events
  output logic period_sync_pulse,
  output logic sync_irq,
  output logic half_status,
  // latched values for the downstream output stages
  output pwm_timing_pkg::word_t segment_control_out,
  output pwm_timing_pkg::word_t min_pulse_active
);
  import pwm_timing_pkg::*;

  // shadow registers written by software
  word_t half_period_count, next_half_period_count;
  dead_t dead_time_count, next_dead_time_count;
  word_t minimum_pulse_count, next_minimum_pulse_count;
  width_t sync_pulse_width, next_sync_pulse_width;
  word_t output_segment_control, next_output_segment_control;
  word_t duty_sh [`PHASES];
  word_t next_duty_sh [`PHASES];
  logic double_mode, next_double_mode;
  logic [3:0] written, next_written;

  // active values used by the timing unit
  word_t tm_act, next_tm_act;
  dead_t dt_act, next_dt_act;
  width_t sw_act, next_sw_act;
  word_t duty_act [`PHASES];
  word_t next_duty_act [`PHASES];

  // timing state
  run_e run_state, next_run_state;
  half_e half_q, next_half_q;
  word_t cnt, next_cnt;
  width_t sync_left, next_sync_left;
  logic next_sync_pulse, next_sync_irq, next_half_status;
  word_t next_rdata, next_segment_out, next_min_pulse;
  logic [2:0] next_high, next_low, gate_hi, gate_lo;
  logic enabled, half_end, sync_rise;

  always_comb begin
    next_half_period_count = half_period_count;
    next_dead_time_count = dead_time_count;
    next_minimum_pulse_count = minimum_pulse_count;
    next_sync_pulse_width = sync_pulse_width;
    next_output_segment_control = output_segment_control;
    next_double_mode = double_mode;
    next_written = written;
    next_duty_sh = duty_sh;
    if (wr_strobe) begin
      case (addr)
        `ADDR_HALF_PERIOD: begin
          next_half_period_count = wdata;
          next_written[0] = 1'b1;
        end
        `ADDR_DEAD_TIME: next_dead_time_count = wdata[9:0];
        `ADDR_MIN_PULSE: next_minimum_pulse_count = wdata;
        `ADDR_SYNC_WIDTH: next_sync_pulse_width = wdata[7:0];
        `ADDR_DUTY_A: begin
          next_duty_sh[0] = wdata;
          next_written[1] = 1'b1;
        end
        `ADDR_DUTY_B: begin
          next_duty_sh[1] = wdata;
          next_written[2] = 1'b1;
        end
        `ADDR_DUTY_C: begin
          next_duty_sh[2] = wdata;
          next_written[3] = 1'b1;
        end
        `ADDR_SEGMENT: next_output_segment_control = wdata;
        `ADDR_MODE: next_double_mode = wdata[`MODE_DOUBLE_BIT];
        default: next_written = written;
      endcase
    end
  end

  // timing: a half period is tm_act clock units, the period two halves
  always_comb begin
    enabled = &written;
    // a zero count ends every cycle rather than wrapping through ffff
    half_end = (run_state == RUNNING) &&
      ({1'b0, cnt} + 17'h00001 >= {1'b0, tm_act});
    sync_rise = ((run_state == STOPPED) && enabled) ||
      (half_end && ((half_q == SECOND_HALF) || double_mode));
    next_run_state = run_state;
    next_half_q = half_q;
    next_cnt = cnt;
    if (run_state == STOPPED) begin
      if (enabled) begin
        next_run_state = RUNNING;
        next_half_q = FIRST_HALF;
        next_cnt = 16'h0000;
      end
    end else if (half_end) begin
      next_cnt = 16'h0000;
      next_half_q = (half_q == FIRST_HALF) ? SECOND_HALF : FIRST_HALF;
    end else begin
      next_cnt = cnt + 16'h0001;
    end
    next_half_status = double_mode && (next_half_q == SECOND_HALF);
  end

  // latching and sync pulse
  always_comb begin
    next_tm_act = tm_act;
    next_dt_act = dt_act;
    next_sw_act = sw_act;
    next_duty_act = duty_act;
    next_segment_out = segment_control_out;
    next_min_pulse = min_pulse_active;
    next_sync_pulse = period_sync_pulse;
    next_sync_left = sync_left;
    if (sync_rise) begin
      next_tm_act = half_period_count;
      next_dt_act = dead_time_count;
      next_sw_act = sync_pulse_width;
      next_duty_act = duty_sh;
      next_min_pulse = minimum_pulse_count;
      next_segment_out = output_segment_control;
      next_sync_pulse = 1'b1;
      next_sync_left = sync_pulse_width;
    end else if (period_sync_pulse) begin
      if (sync_left == 8'h00) begin
        next_sync_pulse = 1'b0;
      end else begin
        next_sync_left = sync_left - 8'h01;
      end
    end
    next_sync_irq = sync_rise;
  end

  // per-phase edges; 18-bit signed so duty above count cannot wrap
  genvar gi;
  generate
    for (gi = 0; gi < `PHASES; gi++) begin : g_phase
      logic signed [17:0] s_t, s_tm, s_d, s_dt;
      always_comb begin
        s_t = signed'({2'b00, cnt});
        s_tm = signed'({2'b00, tm_act});
        s_d = signed'({2'b00, duty_act[gi]});
        s_dt = signed'({8'h00, dt_act});
        if (half_q == FIRST_HALF) begin
          gate_hi[gi] = s_t >= s_tm - s_d + s_dt;
          gate_lo[gi] = s_t + s_dt < s_tm - s_d;
        end else begin
          gate_hi[gi] = s_t + s_dt < s_d;
          gate_lo[gi] = s_t >= s_d + s_dt;
        end
      end
    end
  endgenerate

  always_comb begin
    next_high = (run_state == RUNNING) ? gate_hi : 3'h0;
    next_low = (run_state == RUNNING) ? gate_lo : 3'h0;
    next_rdata = 16'h0000;
    if (rd_strobe) begin
      case (addr)
        `ADDR_HALF_PERIOD: next_rdata = half_period_count;
        `ADDR_DEAD_TIME: next_rdata = {6'h00, dead_time_count};
        `ADDR_MIN_PULSE: next_rdata = minimum_pulse_count;
        `ADDR_SYNC_WIDTH: next_rdata = {8'h00, sync_pulse_width};
        `ADDR_DUTY_A: next_rdata = duty_sh[0];
        `ADDR_DUTY_B: next_rdata = duty_sh[1];
        `ADDR_DUTY_C: next_rdata = duty_sh[2];
        `ADDR_SEGMENT: next_rdata = output_segment_control;
        `ADDR_MODE: next_rdata[`MODE_DOUBLE_BIT] = double_mode;
        `ADDR_STATUS: begin
          next_rdata[`STATUS_HALF_BIT] = half_status;
          next_rdata[`STATUS_RUN_BIT] = (run_state == RUNNING);
        end
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      half_period_count <= `WORD_RESET;
      dead_time_count <= `DEAD_RESET;
      minimum_pulse_count <= `WORD_RESET;
      sync_pulse_width <= `SYNC_WIDTH_RESET;
      output_segment_control <= `WORD_RESET;
      duty_sh <= '{default: `WORD_RESET};
      double_mode <= 1'b0;
      written <= 4'h0;
      tm_act <= `WORD_RESET;
      dt_act <= `DEAD_RESET;
      sw_act <= `SYNC_WIDTH_RESET;
      duty_act <= '{default: `WORD_RESET};
      run_state <= STOPPED;
      half_q <= FIRST_HALF;
      cnt <= `WORD_RESET;
      sync_left <= 8'h00;
      period_sync_pulse <= 1'b0;
      sync_irq <= 1'b0;
      half_status <= 1'b0;
      segment_control_out <= `WORD_RESET;
      min_pulse_active <= `WORD_RESET;
      phase_high_out <= 3'h0;
      phase_low_out <= 3'h0;
      rdata <= 16'h0000;
    end else begin
      half_period_count <= next_half_period_count;
      dead_time_count <= next_dead_time_count;
      minimum_pulse_count <= next_minimum_pulse_count;
      sync_pulse_width <= next_sync_pulse_width;
      output_segment_control <= next_output_segment_control;
      duty_sh <= next_duty_sh;
      double_mode <= next_double_mode;
      written <= next_written;
      tm_act <= next_tm_act;
      dt_act <= next_dt_act;
      sw_act <= next_sw_act;
      duty_act <= next_duty_act;
      run_state <= next_run_state;
      half_q <= next_half_q;
      cnt <= next_cnt;
      sync_left <= next_sync_left;
      period_sync_pulse <= next_sync_pulse;
      sync_irq <= next_sync_irq;
      half_status <= next_half_status;
      segment_control_out <= next_segment_out;
      min_pulse_active <= next_min_pulse;
      phase_high_out <= next_high;
      phase_low_out <= next_low;
      rdata <= next_rdata;
    end
  end

  // checks; hi_len counts the high cycles already past, so it equals the width plus one at the fall
  logic [8:0] hi_len;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      hi_len <= 9'h000;
    end else if (next_sync_irq) begin
      hi_len <= 9'h000;
    end else if (period_sync_pulse) begin
      hi_len <= hi_len + 9'h001;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  AST_RESET_SINGLE: assert property ($rose(nrst) |-> !double_mode)
    else $error("update mode not single after reset");
  AST_IDLE_QUIET: assert property (run_state == STOPPED ##1 run_state == STOPPED |->
    !period_sync_pulse && phase_high_out == 3'h0 && phase_low_out == 3'h0)
    else $error("activity before configuration complete");
  AST_SINGLE_NO_HALF: assert property (!double_mode ##1 !double_mode |-> !half_status)
    else $error("half status set in single mode");
  AST_LATCH_PERIOD: assert property (sync_rise |=> tm_act == $past(half_period_count) &&
    dt_act == $past(dead_time_count) && sw_act == $past(sync_pulse_width))
    else $error("timing values not latched on sync");
  AST_LATCH_SEGMENT: assert property (sync_rise |=>
    segment_control_out == $past(output_segment_control))
    else $error("segment control not latched on sync");
  AST_SYNC_WIDTH: assert property ($fell(period_sync_pulse) |->
    hi_len == {1'b0, sw_act} + 9'h001)
    else $error("sync pulse width wrong");
  AST_IRQ_ON_SYNC: assert property ($rose(period_sync_pulse) |-> sync_irq ##1 !sync_irq)
    else $error("no single interrupt pulse on sync");
  AST_SINGLE_ONE_SYNC: assert property (sync_rise && !double_mode && run_state == RUNNING
    |-> half_q == SECOND_HALF)
    else $error("midpoint sync in single mode");
  AST_DOUBLE_MID_SYNC: assert property (half_end && double_mode |-> sync_rise)
    else $error("missing midpoint sync in double mode");
  AST_HALF_FLAG: assert property (sync_rise && double_mode ##1 double_mode |->
    half_status == (half_q == SECOND_HALF))
    else $error("half status does not follow half");
  AST_NO_OVERLAP: assert property (!(|(phase_high_out & phase_low_out)))
    else $error("both switches of a pair on");
endmodule

`default_nettype wire

// ---- testbench/gate_drive_model.sv ----
// gate driver model for the three inverter legs
// assumes registered active-high gate commands on the same clock
`timescale 1ns/1ps
`default_nettype none

module gate_drive_model (
  // clock
  input wire logic clock,
  // gate commands
  input wire logic [2:0] high_in,
  input wire logic [2:0] low_in,
  // fault count
  output int shoot_count
);
  initial shoot_count = 0;
  // both switches of one leg on would short the dc link
  always @(posedge clock) begin
    if ((high_in & low_in) != 3'h0) begin
      shoot_count <= shoot_count + 1;
    end
  end
endmodule

`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench for the pwm timing core
// assumes the package and defines header are compiled ahead of this file
`include "pwm_timing_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module tb;
  import pwm_timing_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  addr_t addr = 4'h0;
  word_t wdata = 16'h0000;
  logic wr_strobe = 1'b0;
  logic rd_strobe = 1'b0;
  word_t rdata, seg_out, minp_out;
  logic [2:0] hi_out, lo_out;
  logic sync_out, irq_out, half_out;
  int fail_count = 0;
  int checked = 0;
  int shoots, h;
  int n = 0, wid = 0, irqs = 0, halves = 0;
  int hon[3], off[3];

  always #50 clock = ~clock;

  three_phase_pwm_timing_core dut (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata), .phase_high_out(hi_out),
    .phase_low_out(lo_out), .period_sync_pulse(sync_out), .sync_irq(irq_out), .half_status(half_out),
    .segment_control_out(seg_out), .min_pulse_active(minp_out));
  gate_drive_model gates (.clock(clock), .high_in(hi_out), .low_in(lo_out), .shoot_count(shoots));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input addr_t a, input word_t d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_strobe <= 1'b1;
    @(posedge clock);
    wr_strobe <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input addr_t a, input word_t exp, input string name);
    @(posedge clock);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clock);
    rd_strobe <= 1'b0;
    @(negedge clock);
    check(name, rdata, exp);
  endtask

  task automatic wait_rise(input int limit);
    logic prev;
    int k;
    prev = sync_out;
    k = 0;
    do begin
      @(negedge clock);
      k++;
      if (sync_out === 1'b1 && prev !== 1'b1) return;
      prev = sync_out;
    end while (k < limit);
    check("sync_rise", 16'h0000, 16'h0001);
  endtask

  // counts from one sync rise up to the next; entered at a rise
  task automatic stats();
    logic prev;
    n = 0;
    wid = 0;
    irqs = 0;
    halves = 0;
    for (int p = 0; p < 3; p++) begin
      hon[p] = 0;
      off[p] = 0;
    end
    do begin
      n++;
      wid += int'(sync_out === 1'b1);
      irqs += int'(irq_out === 1'b1);
      halves += int'(half_out === 1'b1);
      prev = sync_out;
      @(negedge clock);
      // gates lag the counter by one register stage, so they are counted a cycle later
      for (int p = 0; p < 3; p++) begin
        hon[p] += int'(hi_out[p] === 1'b1);
        off[p] += int'(hi_out[p] === 1'b0 && lo_out[p] === 1'b0);
      end
    end while (!(sync_out === 1'b1 && prev === 1'b0) && n < 300);
  endtask

  task automatic expect_period(input int en, input int ew, input int eon, input int eoff, input int eh);
    stats();
    check("period", 16'(n), 16'(en));
    check("sync_width", 16'(wid), 16'(ew));
    check("irq", 16'(irqs), 16'h0001);
    if (eh >= 0) check("half", 16'(halves), 16'(eh));
    for (int p = 0; p < 3; p++) begin
      check("on_time", 16'(hon[p]), 16'(eon));
      check("dead", 16'(off[p]), 16'(eoff));
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // whole run is well under two thousand cycles
  initial begin
    #(100 * 5000);
    fail_count++;
    give_verdict();
  end

  initial begin
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rd(`ADDR_SYNC_WIDTH, 16'h0027, "sync_width");
    rd(`ADDR_MODE, 16'h0000, "mode");
    rd(4'hf, 16'h0000, "unmapped");
    rd(`ADDR_STATUS, 16'h0000, "status");
    wr(`ADDR_HALF_PERIOD, 16'hffff);
    rd(`ADDR_HALF_PERIOD, 16'hffff, "half_period");
    wr(`ADDR_DEAD_TIME, 16'hffff);
    rd(`ADDR_DEAD_TIME, 16'h03ff, "dead_time");
    wr(`ADDR_SYNC_WIDTH, 16'h0101);
    rd(`ADDR_SYNC_WIDTH, 16'h0001, "sync_width");
    $display("test registers done");
    wr(`ADDR_DEAD_TIME, 16'h0001);
    wr(`ADDR_HALF_PERIOD, 16'h0008);
    wr(`ADDR_DUTY_A, 16'h0004);
    wr(`ADDR_DUTY_B, 16'h0004);
    // one duty still unwritten: timer must stay idle
    repeat (40) begin
      @(negedge clock);
      wid += int'(sync_out === 1'b1);
    end
    check("idle_sync", 16'(wid), 16'h0000);
    wr(`ADDR_DUTY_C, 16'h0004);
    wait_rise(20);
    stats();
    expect_period(16, 2, 6, 4, 0);
    $display("test single update done");
    wr(`ADDR_SEGMENT, 16'h00a5);
    wr(`ADDR_MIN_PULSE, 16'h0003);
    wr(`ADDR_HALF_PERIOD, 16'h0006);
    wr(`ADDR_DEAD_TIME, 16'h0000);
    @(negedge clock);
    check("segment", seg_out, 16'h0000);
    check("min_pulse", minp_out, 16'h0000);
    wait_rise(20);
    check("segment", seg_out, 16'h00a5);
    check("min_pulse", minp_out, 16'h0003);
    stats();
    expect_period(12, 2, 8, 0, 0);
    $display("test latching done");
    rd(`ADDR_STATUS, 16'h0001, "status");
    wr(`ADDR_MODE, 16'h0040);
    rd(`ADDR_MODE, 16'h0040, "mode");
    wait_rise(20);
    stats();
    expect_period(6, 2, 4, 0, -1);
    h = halves;
    expect_period(6, 2, 4, 0, -1);
    check("half_sum", 16'(h + halves), 16'h0006);
    check("half_split", 16'(h * halves), 16'h0000);
    check("shoot", 16'(shoots), 16'h0000);
    $display("test double update done");
    give_verdict();
  end
endmodule

`default_nettype wire
